// *** core/rate_status_pkg.sv ***
// Constants for the main status and rate control register pair
package rate_status_pkg;

  localparam int          ADDR_W          = 3;
  localparam logic [2:0]  REG_OFFSET      = 3'h4;
  localparam int          HOST_REQ_BIT    = 7;
  localparam int          DIR_BIT         = 6;
  localparam int          NON_DMA_BIT     = 5;
  localparam int          CMD_BUSY_BIT    = 4;
  localparam int          SOFT_RESET_BIT  = 7;
  localparam int          POWER_DOWN_BIT  = 6;
  localparam int          SHIFT_LSB       = 2;
  localparam int          SHIFT_W         = 3;
  localparam int          RATE_LSB        = 0;
  localparam int          RATE_W          = 2;
  localparam int          DRIVES          = 4;
  localparam logic [7:0]  RATE_CTRL_RESET = 8'h02;

  // Where the effective rate was last written from
  typedef enum logic {SRC_PRIMARY, SRC_ALT} rate_src_t;

endpackage

// *** core/floppy_status_and_rate_regs.sv ***
// Main status read and rate control write sharing one register offset
//
// Summary of operation
// - Status bit 7 is high only when the data register can take or give a byte.
// - Status bit 6 high means host reads data, low means host writes data.
// - Status bit 5 is set only in a non-DMA execution phase.
// - Status bit 4 is high while a read or write command is processed.
// - Status bits 3 to 0 are high while the matching drive is seeking.
// - A read at offset 4 returns status; a write there sets rate control.
// - Rate control bits 1:0 hold the rate, bits 4:2 the write shift delay.
// - In legacy modes the rate comes from the alternative rate control.
// - Outside legacy mode the rate comes from whichever source was written last; host writes in legacy mode do not switch it.
// - Writing rate control bit 7 high requests a controller soft reset.
// - Rate control bit 6 high puts the controller into power-down.
`timescale 1ns/1ps

module floppy_status_and_rate_regs
  import rate_status_pkg::*;
#(
  parameter int DRIVE_CNT = DRIVES
)(
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic [ADDR_W-1:0]     hostAddr,
  input  wire logic                  hostRd,
  input  wire logic                  hostWr,
  input  wire logic [7:0]            hostWrData,
  output logic      [7:0]            hostRdData,
  input  wire logic                  dataRegReady,
  input  wire logic                  dataToHost,
  input  wire logic                  nonDmaExec,
  input  wire logic                  rwCmdActive,
  input  wire logic [DRIVE_CNT-1:0]  seekActive,
  input  wire logic                  legacyMode,
  input  wire logic                  altRateWr,
  input  wire logic [RATE_W-1:0]     altRateCode,
  output logic      [RATE_W-1:0]     rateCode,
  output logic      [SHIFT_W-1:0]    writeShiftDelay,
  output logic                       powerDown,
  output logic                       softResetReq,
  output logic      [7:0]            mainStatus
);

  logic [7:0]        rateCtrl_r;
  logic [RATE_W-1:0] altRate_r;
  rate_src_t         rateSrc_r;
  logic              regHit;
  logic [7:0]        status_nxt;

  assign regHit = (hostAddr == REG_OFFSET);

  always_comb
  begin
    status_nxt                 = 8'h00;
    status_nxt[HOST_REQ_BIT]   = dataRegReady;
    status_nxt[DIR_BIT]        = dataToHost;
    status_nxt[NON_DMA_BIT]    = nonDmaExec;
    status_nxt[CMD_BUSY_BIT]   = rwCmdActive;
    status_nxt[DRIVE_CNT-1:0]  = seekActive;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      mainStatus <= 8'h00;
    else
      mainStatus <= status_nxt;
  end

  // Read data registered; other offsets read zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      hostRdData <= 8'h00;
    else if (hostRd && regHit)
      hostRdData <= status_nxt;
    else
      hostRdData <= 8'h00;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rateCtrl_r <= RATE_CTRL_RESET;
    else if (hostWr && regHit)
      rateCtrl_r <= hostWrData;
  end

  // Last writer of the rate wins, host writes counting only outside legacy mode; there a same-cycle tie goes to the host write
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rateSrc_r <= SRC_PRIMARY;
      altRate_r <= RATE_CTRL_RESET[RATE_W-1:0];
    end
    else if (hostWr && regHit && !legacyMode)
      rateSrc_r <= SRC_PRIMARY;
    else if (altRateWr)
    begin
      rateSrc_r <= SRC_ALT;
      altRate_r <= altRateCode;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rateCode        <= RATE_CTRL_RESET[RATE_W-1:0];
      writeShiftDelay <= RATE_CTRL_RESET[SHIFT_LSB +: SHIFT_W];
      powerDown       <= 1'b0;
    end
    else
    begin
      if (legacyMode || rateSrc_r == SRC_ALT)
        rateCode <= altRate_r;
      else
        rateCode <= rateCtrl_r[RATE_LSB +: RATE_W];
      writeShiftDelay <= rateCtrl_r[SHIFT_LSB +: SHIFT_W];
      powerDown       <= rateCtrl_r[POWER_DOWN_BIT];
    end
  end

  // One-cycle reset request per write with bit 7 set
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      softResetReq <= 1'b0;
    else
      softResetReq <= hostWr && regHit && hostWrData[SOFT_RESET_BIT];
  end

  // Steps of the rate write and hold checks
  sequence hostRateWr_s;
    hostWr && regHit && !legacyMode && !altRateWr;
  endsequence

  sequence noRateChange_s;
    !altRateWr && !legacyMode;
  endsequence

  sequence legacyHostWr_s;
    legacyMode && hostWr && regHit && !altRateWr;
  endsequence

  sequence legacyQuiet_s;
    legacyMode && !altRateWr;
  endsequence

  sequence altOnlyWr_s;
    !legacyMode && altRateWr && !(hostWr && regHit);
  endsequence

  // Status register checks
  status_track_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !$past(rst) |-> mainStatus[HOST_REQ_BIT] == $past(dataRegReady)
      && mainStatus[DRIVE_CNT-1:0] == $past(seekActive)
      && mainStatus[CMD_BUSY_BIT] == $past(rwCmdActive))
    else $error("status bits do not follow sources");

  dir_track_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !$past(rst) |-> mainStatus[DIR_BIT] == $past(dataToHost))
    else $error("direction bit wrong");

  nondma_track_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !nonDmaExec |=> !mainStatus[NON_DMA_BIT])
    else $error("non-DMA bit set outside execution");

  busy_track_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    rwCmdActive |=> mainStatus[CMD_BUSY_BIT])
    else $error("busy bit low during command");

  seek_track_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(seekActive[0]) |-> ##1 mainStatus[0])
    else $error("drive 0 seek not shown");

  rqm_low_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !dataRegReady |=> !mainStatus[HOST_REQ_BIT])
    else $error("host request shown while not ready");

  // Read path checks
  read_status_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostRd && regHit |=> hostRdData == mainStatus)
    else $error("read did not return status");

  rqm_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostRd && regHit |=> hostRdData[HOST_REQ_BIT] == $past(dataRegReady))
    else $error("read shows wrong host request");

  dir_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostRd && regHit |=> hostRdData[DIR_BIT] == $past(dataToHost))
    else $error("read shows wrong direction");

  nondma_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostRd && regHit && !nonDmaExec |=> !hostRdData[NON_DMA_BIT])
    else $error("read shows non-DMA outside execution");

  busy_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostRd && regHit |=> hostRdData[CMD_BUSY_BIT] == $past(rwCmdActive))
    else $error("read shows wrong busy bit");

  seek_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostRd && regHit |=> hostRdData[DRIVE_CNT-1:0] == $past(seekActive))
    else $error("read shows wrong seek bits");

  idle_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(hostRd && regHit) |=> hostRdData == 8'h00)
    else $error("read data not zero outside a status read");

  // Rate control checks
  miss_write_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(hostWr && regHit) |=> $stable(rateCtrl_r))
    else $error("rate control changed without a write");

  rate_write_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostWr && regHit |=> rateCtrl_r == $past(hostWrData))
    else $error("rate control write not stored");

  shift_write_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostWr && regHit |-> ##2
      writeShiftDelay == $past(hostWrData[SHIFT_LSB +: SHIFT_W], 2))
    else $error("shift delay not updated");

  config_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(hostWr && regHit) |-> ##2
      $stable(writeShiftDelay) && $stable(powerDown))
    else $error("shift delay or power-down changed without a write");

  legacy_rate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    legacyMode && altRateWr && !(hostWr && regHit) |-> ##2
      rateCode == $past(altRateCode, 2))
    else $error("legacy rate not from alt source");

  legacy_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    legacyHostWr_s ##1 legacyQuiet_s |=> $stable(rateCode))
    else $error("host write changed the legacy rate");

  last_rate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostRateWr_s ##1 noRateChange_s
      |=> rateCode == $past(hostWrData[RATE_LSB +: RATE_W], 2))
    else $error("latest rate write not used");

  alt_wins_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    altOnlyWr_s |-> ##2
      rateCode == $past(altRateCode, 2))
    else $error("latest alternative rate not used");

  tie_host_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostWr && regHit && !legacyMode && altRateWr |=> rateSrc_r == SRC_PRIMARY)
    else $error("host write lost a same-cycle tie");

  soft_reset_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostWr && regHit && hostWrData[SOFT_RESET_BIT] |=> softResetReq ##1
      !(softResetReq && !$past(hostWr && regHit)))
    else $error("soft reset request missing");

  pulse_cause_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    softResetReq |-> $past(hostWr && regHit && hostWrData[SOFT_RESET_BIT]))
    else $error("soft reset request without a write");

  no_request_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostWr && regHit && !hostWrData[SOFT_RESET_BIT] |=> !softResetReq)
    else $error("soft reset request from a clear bit");

  power_down_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hostWr && regHit |-> ##2
      powerDown == $past(hostWrData[POWER_DOWN_BIT], 2))
    else $error("power-down bit not applied");

  // Reset checks
  reset_value_a: assert property (
    @(posedge ref_clk)
    $past(rst) |-> rateCtrl_r == RATE_CTRL_RESET && !mainStatus[HOST_REQ_BIT])
    else $error("reset values wrong");

  reset_clear_a: assert property (
    @(posedge ref_clk)
    rst |=> mainStatus == 8'h00 && hostRdData == 8'h00
      && rateCode == RATE_CTRL_RESET[RATE_W-1:0] && !softResetReq)
    else $error("outputs not cleared by reset");

endmodule

// *** dv/host_model.sv ***
// Host processor model issuing single register reads and writes
`timescale 1ns/1ps

module host_model
  import rate_status_pkg::*;
(
  input  wire logic              ref_clk,
  output logic      [ADDR_W-1:0] hostAddr,
  output logic                   hostRd,
  output logic                   hostWr,
  output logic      [7:0]        hostWrData
);
  initial {hostAddr, hostRd, hostWr, hostWrData} = '0;

  // Strobe stands one edge; released lines show the inverse of the last value
  task automatic access(input logic [ADDR_W-1:0] a, input logic w,
                        input logic [7:0] d);
    @(posedge ref_clk);
    hostAddr   <= a;
    hostWr     <= w;
    hostRd     <= !w;
    hostWrData <= d;
    @(posedge ref_clk);
    hostWr     <= 1'b0;
    hostRd     <= 1'b0;
    hostAddr   <= ~a;
    hostWrData <= ~d;
  endtask
endmodule

// *** dv/floppy_status_and_rate_regs_bench.sv ***
// Bench for the status and rate control register pair
`timescale 1ns/1ps

module floppy_status_and_rate_regs_bench
  import rate_status_pkg::*;
;
  logic              ref_clk = 0, rst = 1, hostRd, hostWr, softResetReq;
  logic              dataRegReady = 0, dataToHost = 0, nonDmaExec = 0;
  logic              rwCmdActive = 0, legacyMode = 0, altRateWr = 0;
  logic              powerDown;
  logic [ADDR_W-1:0] hostAddr;
  logic [7:0]        hostWrData, hostRdData, mainStatus;
  logic [3:0]        seekActive = 0;
  logic [1:0]        altRateCode = 0, rateCode;
  logic [2:0]        writeShiftDelay;
  int                miscompares = 0, checks = 0, cycles = 0;
  // Write data, expected rate, write shift delay, power-down
  logic [7:0]        rows [4][4] = '{'{8'h47, 8'h03, 8'h01, 8'h01},
    '{8'h1C, 8'h00, 8'h07, 8'h00}, '{8'h01, 8'h01, 8'h00, 8'h00},
    '{8'h3E, 8'h02, 8'h07, 8'h00}};

  always #5 ref_clk = ~ref_clk;
  host_model i_host (.ref_clk, .hostAddr, .hostRd, .hostWr, .hostWrData);
  floppy_status_and_rate_regs i_dut (.ref_clk, .rst, .hostAddr, .hostRd,
    .hostWr, .hostWrData, .hostRdData, .dataRegReady, .dataToHost,
    .nonDmaExec, .rwCmdActive, .seekActive, .legacyMode, .altRateWr,
    .altRateCode, .rateCode, .writeShiftDelay, .powerDown, .softResetReq,
    .mainStatus);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    i_host.access(REG_OFFSET, 1'b1, d);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk({rateCode, writeShiftDelay, powerDown, mainStatus[7]}, 8'h40);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(rows[i][0]);
      chk(rateCode, rows[i][1]);
      chk(writeShiftDelay, rows[i][2]);
      chk(powerDown, rows[i][3]);
    end
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      {dataRegReady, dataToHost, nonDmaExec, rwCmdActive, seekActive}
        <= 8'h01 << i;
      repeat (2) @(posedge ref_clk);
      i_host.access(REG_OFFSET, 1'b0, 8'h00);
      #1;
      chk(hostRdData, 8'h01 << i);
      chk(mainStatus, 8'h01 << i);
    end
    $display("table test done");
    i_host.access(REG_OFFSET, 1'b1, 8'h80);
    #1;
    chk(softResetReq, 8'h01);
    @(posedge ref_clk);
    #1;
    chk(softResetReq, 0);
    i_host.access(3'h5, 1'b1, 8'hFF);
    i_host.access(3'h0, 1'b0, 8'h00);
    #1;
    chk(hostRdData, 8'h00);
    chk({softResetReq, rateCode}, 8'h00);
    @(posedge ref_clk);
    legacyMode <= 1'b1;
    wr(8'h03);
    chk(rateCode, 8'h02);
    @(posedge ref_clk);
    altRateWr   <= 1'b1;
    altRateCode <= 2'h1;
    @(posedge ref_clk);
    altRateWr   <= 1'b0;
    legacyMode  <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(rateCode, 8'h01);
    wr(8'h00);
    chk(rateCode, 8'h00);
    $display("awkward test done");
    end_of_test();
  end
endmodule
